// ==== hdl/sgram_state_pkg.sv ====
package sgram_state_pkg;

    // command encoding {cs_n, ras_n, cas_n, we_n, special_function_flag}
    typedef enum logic [3:0] {
        CMD_DESELECT,
        CMD_NOP,
        CMD_BURST_STOP,
        CMD_READ,
        CMD_WRITE,
        CMD_ACTIVATE,
        CMD_PRECHARGE,
        CMD_REFRESH,
        CMD_MODE_LOAD,
        CMD_ACTIVATE_MASKED,
        CMD_BLOCK_WRITE,
        CMD_SPECIAL_MODE_LOAD,
        CMD_UNDEFINED
    } cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ROW_ACTIVE,
        ST_READ,
        ST_READ_AP,
        ST_WRITE,
        ST_WRITE_AP,
        ST_PRECHARGE,
        ST_REFRESH,
        ST_SELF_REFRESH,
        ST_POWER_DOWN
    } state_t;

    localparam int BANK_BIT      = 9;
    localparam int AP_BIT        = 8;
    localparam int ADDR_W        = 10;
    localparam int REF_ADDR_W    = 10;
    localparam int CNT_W         = 8;
    localparam int CLK_PERIOD_NS = 10;

    // interval figures in ns, counts rounded up to whole cycles
    localparam int ROW_PRECHARGE_INTERVAL_NS = 30;
    localparam int ROW_CYCLE_INTERVAL_NS     = 90;
    localparam int ROW_PRECHARGE_CYCLES =
        (ROW_PRECHARGE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_CYCLE_CYCLES =
        (ROW_CYCLE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [REF_ADDR_W-1:0] REF_ADDR_RESET = 10'h000;
    localparam logic [CNT_W-1:0]      CNT_RESET      = 8'h00;

endpackage : sgram_state_pkg

// ==== hdl/sgram_cmd_decode.sv ====
`timescale 1ns/1ps
module sgram_cmd_decode (
    // command pins
    input  wire logic cs_n,
    input  wire logic ras_n,
    input  wire logic cas_n,
    input  wire logic we_n,
    input  wire logic special_function_flag,
    // decoded command
    output sgram_state_pkg::cmd_t cmd
);
    always_comb begin
        if (cs_n) begin
            cmd = sgram_state_pkg::CMD_DESELECT;
        end else begin
            unique case ({ras_n, cas_n, we_n, special_function_flag})
                4'b1110: cmd = sgram_state_pkg::CMD_NOP;
                4'b1100: cmd = sgram_state_pkg::CMD_BURST_STOP;
                4'b1010: cmd = sgram_state_pkg::CMD_READ;
                4'b1000: cmd = sgram_state_pkg::CMD_WRITE;
                4'b0110: cmd = sgram_state_pkg::CMD_ACTIVATE;
                4'b0100: cmd = sgram_state_pkg::CMD_PRECHARGE;
                4'b0010: cmd = sgram_state_pkg::CMD_REFRESH;
                4'b0000: cmd = sgram_state_pkg::CMD_MODE_LOAD;
                4'b0111: cmd = sgram_state_pkg::CMD_ACTIVATE_MASKED;
                4'b1001: cmd = sgram_state_pkg::CMD_BLOCK_WRITE;
                4'b0001: cmd = sgram_state_pkg::CMD_SPECIAL_MODE_LOAD;
                default: cmd = sgram_state_pkg::CMD_UNDEFINED;
            endcase
        end
    end
endmodule : sgram_cmd_decode

// ==== hdl/sgram_power_and_command_state.sv ====
`timescale 1ns/1ps
module sgram_power_and_command_state #(
    parameter int BURST_LEN = 4
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // command pins
    input  wire logic        clk_en,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic        special_function_flag,
    input  wire logic [9:0]  addr,
    input  wire logic        full_page,
    // state view
    output sgram_state_pkg::state_t state,
    output logic [1:0]       bank_active,
    output logic             suspended,
    output logic             burst_busy,
    output logic             write_mask_en,
    output logic             refresh_busy,
    output logic [9:0]       refresh_addr,
    output logic             mode_load_pulse,
    output logic             special_mode_load_pulse,
    output logic             illegal_cmd
);
    // the controller runs on this clock: a synchroniser would repeat every command
    logic cke_prev_q;
    logic cke_now;

    // reset to the idle level of clock enable, so no false edge follows reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cke_prev_q <= 1'b1;
        end else begin
            cke_prev_q <= clk_en;
        end
    end

    assign cke_now = clk_en;

    sgram_state_pkg::cmd_t cmd;
    sgram_cmd_decode u_decode (
        .cs_n                  (cs_n),
        .ras_n                 (ras_n),
        .cas_n                 (cas_n),
        .we_n                  (we_n),
        .special_function_flag (special_function_flag),
        .cmd                   (cmd)
    );

    function automatic logic is_nop_like(input sgram_state_pkg::cmd_t c);
        return c == sgram_state_pkg::CMD_DESELECT || c == sgram_state_pkg::CMD_NOP;
    endfunction : is_nop_like

    logic bank_sel;
    assign bank_sel = addr[sgram_state_pkg::BANK_BIT];
    logic ap_bit;
    assign ap_bit = addr[sgram_state_pkg::AP_BIT];

    sgram_state_pkg::state_t state_q, state_d;
    logic [1:0] bank_q, bank_d;
    logic       susp_q, susp_d;
    logic [7:0] cnt_q, cnt_d;
    logic       mask_q, mask_d;
    logic       illegal_d, mload_d, smload_d, ref_inc;
    logic       cmd_cycle;

    // commands only act with clock enable high in the previous cycle
    assign cmd_cycle = cke_prev_q && !susp_q;

    always_comb begin
        state_d   = state_q;
        bank_d    = bank_q;
        susp_d    = susp_q;
        cnt_d     = cnt_q;
        mask_d    = mask_q;
        illegal_d = 1'b0;
        mload_d   = 1'b0;
        smload_d  = 1'b0;
        ref_inc   = 1'b0;
        // internal operations continue regardless of suspend
        if ((state_q == sgram_state_pkg::ST_READ || state_q == sgram_state_pkg::ST_WRITE
             || state_q == sgram_state_pkg::ST_READ_AP
             || state_q == sgram_state_pkg::ST_WRITE_AP) && !full_page) begin
            if (cnt_q != 8'h00) cnt_d = cnt_q - 8'h01;
        end
        if (susp_q) begin
            if (cke_now) susp_d = 1'b0;
        end
        unique case (state_q)
            sgram_state_pkg::ST_IDLE: begin
                if (cke_prev_q && !cke_now) begin
                    if (cmd == sgram_state_pkg::CMD_REFRESH) begin
                        state_d = sgram_state_pkg::ST_SELF_REFRESH;
                    end else if (cmd == sgram_state_pkg::CMD_NOP) begin
                        state_d = sgram_state_pkg::ST_POWER_DOWN;
                    end
                end else if (cmd_cycle) begin
                    unique case (cmd)
                        sgram_state_pkg::CMD_REFRESH: begin
                            state_d = sgram_state_pkg::ST_REFRESH;
                            cnt_d   = 8'(sgram_state_pkg::ROW_CYCLE_CYCLES - 1);
                            ref_inc = 1'b1;
                        end
                        sgram_state_pkg::CMD_ACTIVATE,
                        sgram_state_pkg::CMD_ACTIVATE_MASKED: begin
                            state_d = sgram_state_pkg::ST_ROW_ACTIVE;
                            bank_d  = bank_sel ? 2'b10 : 2'b01;
                            mask_d  = (cmd == sgram_state_pkg::CMD_ACTIVATE_MASKED);
                        end
                        sgram_state_pkg::CMD_MODE_LOAD: mload_d = 1'b1;
                        sgram_state_pkg::CMD_SPECIAL_MODE_LOAD: smload_d = 1'b1;
                        sgram_state_pkg::CMD_READ, sgram_state_pkg::CMD_WRITE,
                        sgram_state_pkg::CMD_BLOCK_WRITE,
                        sgram_state_pkg::CMD_UNDEFINED: illegal_d = 1'b1;
                        default: ;
                    endcase
                end
            end
            sgram_state_pkg::ST_REFRESH: begin
                if (cmd_cycle && !(is_nop_like(cmd) || cmd == sgram_state_pkg::CMD_BURST_STOP))
                    illegal_d = 1'b1;
                if (cnt_q == 8'h00) begin
                    state_d = sgram_state_pkg::ST_IDLE;
                    bank_d  = 2'b00;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            sgram_state_pkg::ST_SELF_REFRESH: begin
                if (!cke_prev_q && cke_now && is_nop_like(cmd))
                    state_d = sgram_state_pkg::ST_IDLE;
            end
            sgram_state_pkg::ST_POWER_DOWN: begin
                if (!cke_prev_q && cke_now && is_nop_like(cmd))
                    state_d = sgram_state_pkg::ST_IDLE;
            end
            sgram_state_pkg::ST_PRECHARGE: begin
                if (cmd_cycle && !is_nop_like(cmd)) illegal_d = 1'b1;
                if (cnt_q == 8'h00) state_d = sgram_state_pkg::ST_IDLE;
                else cnt_d = cnt_q - 8'h01;
            end
            default: begin
                // row active, read, write and auto precharge states
                if (cke_prev_q && !cke_now) begin
                    susp_d = 1'b1;
                end else if (cmd_cycle) begin
                    unique case (cmd)
                        sgram_state_pkg::CMD_DESELECT, sgram_state_pkg::CMD_NOP: ;
                        sgram_state_pkg::CMD_ACTIVATE,
                        sgram_state_pkg::CMD_ACTIVATE_MASKED: begin
                            if (bank_q[bank_sel]) begin
                                illegal_d = 1'b1;
                            end else begin
                                bank_d[bank_sel] = 1'b1;
                                if (cmd == sgram_state_pkg::CMD_ACTIVATE_MASKED)
                                    mask_d = 1'b1;
                            end
                        end
                        default: begin
                            if (state_q == sgram_state_pkg::ST_READ_AP
                                || state_q == sgram_state_pkg::ST_WRITE_AP) begin
                                illegal_d = 1'b1;
                            end else begin
                                unique case (cmd)
                                    sgram_state_pkg::CMD_BURST_STOP: begin
                                        if (state_q != sgram_state_pkg::ST_ROW_ACTIVE)
                                            state_d = sgram_state_pkg::ST_ROW_ACTIVE;
                                    end
                                    sgram_state_pkg::CMD_READ: begin
                                        state_d = ap_bit ? sgram_state_pkg::ST_READ_AP
                                                         : sgram_state_pkg::ST_READ;
                                        cnt_d   = 8'(BURST_LEN - 1);
                                    end
                                    sgram_state_pkg::CMD_WRITE,
                                    sgram_state_pkg::CMD_BLOCK_WRITE: begin
                                        state_d = ap_bit ? sgram_state_pkg::ST_WRITE_AP
                                                         : sgram_state_pkg::ST_WRITE;
                                        cnt_d   = (cmd == sgram_state_pkg::CMD_BLOCK_WRITE)
                                                  ? 8'h00 : 8'(BURST_LEN - 1);
                                    end
                                    sgram_state_pkg::CMD_PRECHARGE: begin
                                        if (ap_bit || bank_q == (bank_sel ? 2'b10 : 2'b01)) begin
                                            state_d = sgram_state_pkg::ST_PRECHARGE;
                                            bank_d  = 2'b00;
                                            mask_d  = 1'b0;
                                            cnt_d   = 8'(sgram_state_pkg::ROW_PRECHARGE_CYCLES - 1);
                                        end else begin
                                            bank_d[bank_sel] = 1'b0;
                                        end
                                    end
                                    sgram_state_pkg::CMD_SPECIAL_MODE_LOAD: begin
                                        if (state_q == sgram_state_pkg::ST_ROW_ACTIVE)
                                            smload_d = 1'b1;
                                        else
                                            illegal_d = 1'b1;
                                    end
                                    default: illegal_d = 1'b1;
                                endcase
                            end
                        end
                    endcase
                end
                // burst completion, also under suspend
                if (state_d == state_q && cnt_q == 8'h00 && !full_page) begin
                    unique case (state_q)
                        sgram_state_pkg::ST_READ, sgram_state_pkg::ST_WRITE:
                            state_d = sgram_state_pkg::ST_ROW_ACTIVE;
                        sgram_state_pkg::ST_READ_AP, sgram_state_pkg::ST_WRITE_AP: begin
                            state_d = sgram_state_pkg::ST_PRECHARGE;
                            bank_d  = 2'b00;
                            mask_d  = 1'b0;
                            cnt_d   = 8'(sgram_state_pkg::ROW_PRECHARGE_CYCLES - 1);
                        end
                        default: ;
                    endcase
                end
            end
        endcase
        if (illegal_d) begin
            state_d = state_q;
            bank_d  = bank_q;
            mask_d  = mask_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= sgram_state_pkg::ST_IDLE;
            bank_q  <= 2'b00;
            susp_q  <= 1'b0;
            cnt_q   <= sgram_state_pkg::CNT_RESET;
            mask_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            bank_q  <= bank_d;
            susp_q  <= susp_d;
            cnt_q   <= cnt_d;
            mask_q  <= mask_d;
        end
    end

    // refresh counter wraps so the full array is covered every 1024 refreshes
    logic [9:0] ref_addr_q;
    always_ff @(posedge clk) begin
        if (sys_rst) ref_addr_q <= sgram_state_pkg::REF_ADDR_RESET;
        else if (ref_inc) ref_addr_q <= ref_addr_q + 10'h001;
    end

    logic illegal_q, mload_q, smload_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            illegal_q <= 1'b0;
            mload_q   <= 1'b0;
            smload_q  <= 1'b0;
        end else begin
            illegal_q <= illegal_d;
            mload_q   <= mload_d;
            smload_q  <= smload_d;
        end
    end

    assign state                   = state_q;
    assign bank_active             = bank_q;
    assign suspended               = susp_q;
    assign write_mask_en           = mask_q;
    assign refresh_busy            = (state_q == sgram_state_pkg::ST_REFRESH);
    assign refresh_addr            = ref_addr_q;
    assign burst_busy              = (state_q == sgram_state_pkg::ST_READ)
                                  || (state_q == sgram_state_pkg::ST_READ_AP)
                                  || (state_q == sgram_state_pkg::ST_WRITE)
                                  || (state_q == sgram_state_pkg::ST_WRITE_AP);
    assign mode_load_pulse         = mload_q;
    assign special_mode_load_pulse = smload_q;
    assign illegal_cmd             = illegal_q;

    a_idle_no_bank: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == sgram_state_pkg::ST_IDLE |-> bank_q == 2'b00)
        else $error("bank active in idle");

    a_refresh_counts: assert property (@(posedge clk) disable iff (sys_rst)
        ref_inc |=> ref_addr_q == $past(ref_addr_q) + 10'h001)
        else $error("refresh address did not advance");

    a_refresh_ends: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(refresh_busy) |-> ##[1:20] state_q == sgram_state_pkg::ST_IDLE)
        else $error("auto refresh did not return to idle");

    a_suspend_entry: assert property (@(posedge clk) disable iff (sys_rst)
        (cke_prev_q && !cke_now && !susp_q && bank_q != 2'b00
         && state_q != sgram_state_pkg::ST_PRECHARGE) |=> susp_q)
        else $error("clock suspend not entered");

    a_suspend_exit: assert property (@(posedge clk) disable iff (sys_rst)
        susp_q && cke_now |=> !susp_q)
        else $error("clock suspend not left");

    a_illegal_holds: assert property (@(posedge clk) disable iff (sys_rst)
        illegal_d |=> state_q == $past(state_q) && illegal_cmd)
        else $error("illegal command changed state");

    a_precharge_ends: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(state_q == sgram_state_pkg::ST_PRECHARGE) |-> ##[1:10]
        state_q == sgram_state_pkg::ST_IDLE)
        else $error("precharge did not reach idle");

    a_power_down_entry: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == sgram_state_pkg::ST_IDLE && cke_prev_q && !cke_now
        && cmd == sgram_state_pkg::CMD_NOP |=> state_q == sgram_state_pkg::ST_POWER_DOWN)
        else $error("power down not entered");

    a_self_refresh_entry: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == sgram_state_pkg::ST_IDLE && cke_prev_q && !cke_now
        && cmd == sgram_state_pkg::CMD_REFRESH |=> state_q == sgram_state_pkg::ST_SELF_REFRESH)
        else $error("self refresh not entered");

    a_power_down_exit: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == sgram_state_pkg::ST_POWER_DOWN && !cke_prev_q && cke_now
        && is_nop_like(cmd) |=> state_q == sgram_state_pkg::ST_IDLE)
        else $error("power down not left");

endmodule : sgram_power_and_command_state

// ==== dv/sgram_ctrl_model.sv ====
`timescale 1ns/1ps
module sgram_ctrl_model (
    // request from the bench
    input  wire logic            clk,
    input  sgram_state_pkg::cmd_t cmd_req,
    input  wire logic            bank_req,
    input  wire logic            ap_req,
    input  wire logic [7:0]      low_req,
    input  wire logic            cke_req,
    // pins toward the device
    output logic                 clk_en,
    output logic                 cs_n,
    output logic                 ras_n,
    output logic                 cas_n,
    output logic                 we_n,
    output logic                 special_function_flag,
    output logic [9:0]           addr
);
    logic       toggle_q = 1'b0;
    logic [4:0] pins;

    // requests change at the falling edge, so every pin is settled at the rising edge
    always @(negedge clk) toggle_q <= ~toggle_q;
    always_comb begin
        case (cmd_req)
            sgram_state_pkg::CMD_NOP:               pins = 5'h0E;
            sgram_state_pkg::CMD_BURST_STOP:        pins = 5'h0C;
            sgram_state_pkg::CMD_READ:              pins = 5'h0A;
            sgram_state_pkg::CMD_WRITE:             pins = 5'h08;
            sgram_state_pkg::CMD_ACTIVATE:          pins = 5'h06;
            sgram_state_pkg::CMD_PRECHARGE:         pins = 5'h04;
            // refresh is also requested with both banks open, where it must be flagged illegal
            sgram_state_pkg::CMD_REFRESH:           pins = 5'h02;
            sgram_state_pkg::CMD_MODE_LOAD:         pins = 5'h00;
            sgram_state_pkg::CMD_ACTIVATE_MASKED:   pins = 5'h07;
            sgram_state_pkg::CMD_BLOCK_WRITE:       pins = 5'h09;
            sgram_state_pkg::CMD_SPECIAL_MODE_LOAD: pins = 5'h01;
            // unselected: the strobes wander instead of holding the last command
            default:                                pins = {1'b1, {4{toggle_q}}};
        endcase
    end
    assign {cs_n, ras_n, cas_n, we_n, special_function_flag} = pins;
    assign addr   = {bank_req, ap_req, low_req};
    assign clk_en = cke_req;
endmodule : sgram_ctrl_model

// ==== dv/sgram_power_and_command_state_bench.sv ====
`timescale 1ns/1ps
module sgram_power_and_command_state_bench;
    logic                    clk = 1'b0;
    logic                    sys_rst;
    logic                    full_page;
    logic                    cke_req;
    logic                    bank_req;
    logic                    ap_req;
    logic [7:0]              low_req;
    logic [31:0]             seed;
    sgram_state_pkg::cmd_t   cmd_req;
    logic                    clk_en;
    logic                    cs_n;
    logic                    ras_n;
    logic                    cas_n;
    logic                    we_n;
    logic                    special_function_flag;
    logic [9:0]              addr;
    sgram_state_pkg::state_t state;
    logic [1:0]              bank_active;
    logic [9:0]              refresh_addr;
    logic                    illegal_cmd;
    logic                    ill_seen;
    logic                    suspended;
    logic                    write_mask_en;
    logic                    burst_busy;
    logic                    refresh_busy;
    logic                    mode_load_pulse;
    logic                    special_mode_load_pulse;
    logic [1:0]              load_seen;
    logic [5:0]              flag_q[$];
    logic [17:0]             exp_q[$];
    int                      errors;
    int                      total_checks;
    event                    result_ev;
    event                    flag_ev;

    sgram_ctrl_model i_sgram_ctrl_model (.clk(clk), .cmd_req(cmd_req), .bank_req(bank_req),
        .ap_req(ap_req), .low_req(low_req), .cke_req(cke_req), .clk_en(clk_en), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .special_function_flag(special_function_flag), .addr(addr));
    sgram_power_and_command_state i_sgram_power_and_command_state (.clk(clk),
        .sys_rst(sys_rst), .clk_en(clk_en), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .special_function_flag(special_function_flag), .addr(addr),
        .full_page(full_page), .state(state), .bank_active(bank_active),
        .suspended(suspended), .burst_busy(burst_busy), .write_mask_en(write_mask_en),
        .refresh_busy(refresh_busy), .refresh_addr(refresh_addr),
        .mode_load_pulse(mode_load_pulse),
        .special_mode_load_pulse(special_mode_load_pulse), .illegal_cmd(illegal_cmd));

    initial forever #5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic chk(input string what, input logic [10:0] e, input logic [10:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic final_report();
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // one command for one cycle, since every sampled cycle is a command; then nop
    task automatic step(input sgram_state_pkg::cmd_t c, input logic b, input logic ap,
                        input logic ck, input sgram_state_pkg::state_t st,
                        input logic [1:0] bk, input logic il, input logic [10:0] rf,
                        input int hold);
        seed = xs(seed);
        cmd_req = c;
        bank_req = b;
        ap_req = ap;
        cke_req = ck;
        low_req = seed[7:0];
        @(negedge clk);
        cmd_req = sgram_state_pkg::CMD_NOP;
        repeat (hold) @(negedge clk);
        exp_q.push_back({st, bk, il, rf});
        -> result_ev;
    endtask : step

    // note of {suspended, write_mask_en, burst_busy, refresh_busy, mode loads seen}
    task automatic flags(input logic [5:0] f);
        flag_q.push_back(f);
        -> flag_ev;
    endtask : flags

    always @(posedge clk) begin
        if (illegal_cmd === 1'b1) ill_seen = 1'b1;
        if (mode_load_pulse === 1'b1) load_seen[1] = 1'b1;
        if (special_mode_load_pulse === 1'b1) load_seen[0] = 1'b1;
    end

    initial begin : flag_watcher
        logic [5:0] f;
        forever begin
            @(flag_ev);
            f = flag_q.pop_front();
            chk("suspended", 11'(f[5]), 11'(suspended));
            chk("write_mask_en", 11'(f[4]), 11'(write_mask_en));
            chk("burst_busy", 11'(f[3]), 11'(burst_busy));
            chk("refresh_busy", 11'(f[2]), 11'(refresh_busy));
            chk("mode_load_pulse", 11'(f[1]), 11'(load_seen[1]));
            chk("special_mode_load_pulse", 11'(f[0]), 11'(load_seen[0]));
            load_seen = 2'b00;
        end
    end

    initial begin : watcher
        logic [17:0] e;
        forever begin
            @(result_ev);
            e = exp_q.pop_front();
            chk("state", 11'(e[17:14]), 11'(state));
            chk("bank_active", 11'(e[13:12]), 11'(bank_active));
            chk("illegal_cmd", 11'(e[11]), 11'(ill_seen));
            if (e[10]) chk("refresh_addr", 11'(e[9:0]), 11'(refresh_addr));
            ill_seen = 1'b0;
        end
    end

    // the full refresh sweep runs near 13300 cycles, so this only fires on a hang
    initial begin
        #200000;
        errors++;
        final_report();
    end

    initial begin
        sys_rst = 1'b1;
        full_page = 1'b0;
        cke_req = 1'b1;
        cmd_req = sgram_state_pkg::CMD_DESELECT;
        {bank_req, ap_req, low_req} = 10'h000;
        seed = 32'h63A8362D;
        errors = 0;
        total_checks = 0;
        ill_seen = 1'b0;
        load_seen = 2'b00;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (8) @(negedge clk);
        ill_seen = 1'b0;
        step(sgram_state_pkg::CMD_NOP, 0, 0, 1, sgram_state_pkg::ST_IDLE, 0, 0, 11'h400, 8);
        step(sgram_state_pkg::CMD_SPECIAL_MODE_LOAD, 0, 0, 1, sgram_state_pkg::ST_IDLE, 0, 0, 0, 8);
        step(sgram_state_pkg::CMD_MODE_LOAD, 0, 0, 1, sgram_state_pkg::ST_IDLE, 0, 0, 0, 8);
        flags(6'h03);
        step(sgram_state_pkg::CMD_ACTIVATE, 0, 0, 1, sgram_state_pkg::ST_ROW_ACTIVE, 1, 0, 0, 8);
        step(sgram_state_pkg::CMD_ACTIVATE, 0, 0, 1, sgram_state_pkg::ST_ROW_ACTIVE, 1, 1, 0, 8);
        step(sgram_state_pkg::CMD_SPECIAL_MODE_LOAD, 0, 0, 1, sgram_state_pkg::ST_ROW_ACTIVE, 1, 0, 0, 8);
        step(sgram_state_pkg::CMD_ACTIVATE_MASKED, 1, 0, 1, sgram_state_pkg::ST_ROW_ACTIVE, 3, 0, 0, 8);
        flags(6'h11);
        step(sgram_state_pkg::CMD_ACTIVATE_MASKED, 1, 0, 1, sgram_state_pkg::ST_ROW_ACTIVE, 3, 1, 0, 8);
        full_page = 1'b1;
        step(sgram_state_pkg::CMD_READ, 0, 0, 1, sgram_state_pkg::ST_READ, 3, 0, 0, 8);
        flags(6'h18);
        step(sgram_state_pkg::CMD_MODE_LOAD, 0, 0, 1, sgram_state_pkg::ST_READ, 3, 1, 0, 8);
        step(sgram_state_pkg::CMD_SPECIAL_MODE_LOAD, 0, 0, 1, sgram_state_pkg::ST_READ, 3, 1, 0, 8);
        step(sgram_state_pkg::CMD_REFRESH, 0, 0, 1, sgram_state_pkg::ST_READ, 3, 1, 0, 8);
        step(sgram_state_pkg::CMD_BURST_STOP, 0, 0, 1, sgram_state_pkg::ST_ROW_ACTIVE, 3, 0, 0, 8);
        step(sgram_state_pkg::CMD_WRITE, 0, 0, 1, sgram_state_pkg::ST_WRITE, 3, 0, 0, 8);
        full_page = 1'b0;
        step(sgram_state_pkg::CMD_PRECHARGE, 0, 0, 1, sgram_state_pkg::ST_ROW_ACTIVE, 2, 0, 0, 12);
        step(sgram_state_pkg::CMD_READ, 1, 1, 1, sgram_state_pkg::ST_IDLE, 0, 0, 0, 18);
        step(sgram_state_pkg::CMD_ACTIVATE, 0, 0, 1, sgram_state_pkg::ST_ROW_ACTIVE, 1, 0, 0, 8);
        step(sgram_state_pkg::CMD_WRITE, 0, 1, 1, sgram_state_pkg::ST_IDLE, 0, 0, 0, 18);
        step(sgram_state_pkg::CMD_REFRESH, 0, 0, 1, sgram_state_pkg::ST_REFRESH, 0, 0, 11'h401, 4);
        flags(6'h04);
        step(sgram_state_pkg::CMD_BURST_STOP, 0, 0, 1, sgram_state_pkg::ST_IDLE, 0, 0, 11'h401, 14);
        step(sgram_state_pkg::CMD_REFRESH, 0, 0, 1, sgram_state_pkg::ST_IDLE, 0, 0, 11'h402, 20);
        // sweep the whole array; the refresh address must wrap back to zero
        repeat (1021)
            step(sgram_state_pkg::CMD_REFRESH, 0, 0, 1, sgram_state_pkg::ST_IDLE, 0, 0, 0, 12);
        step(sgram_state_pkg::CMD_REFRESH, 0, 0, 1, sgram_state_pkg::ST_IDLE, 0, 0, 11'h400, 12);
        step(sgram_state_pkg::CMD_REFRESH, 0, 0, 0, sgram_state_pkg::ST_SELF_REFRESH, 0, 0, 0, 8);
        step(sgram_state_pkg::CMD_NOP, 0, 0, 1, sgram_state_pkg::ST_IDLE, 0, 0, 0, 8);
        step(sgram_state_pkg::CMD_NOP, 0, 0, 0, sgram_state_pkg::ST_POWER_DOWN, 0, 0, 0, 8);
        step(sgram_state_pkg::CMD_DESELECT, 0, 0, 1, sgram_state_pkg::ST_IDLE, 0, 0, 0, 8);
        step(sgram_state_pkg::CMD_ACTIVATE, 1, 0, 1, sgram_state_pkg::ST_ROW_ACTIVE, 2, 0, 0, 8);
        step(sgram_state_pkg::CMD_NOP, 0, 0, 0, sgram_state_pkg::ST_ROW_ACTIVE, 2, 0, 0, 8);
        flags(6'h20);
        step(sgram_state_pkg::CMD_PRECHARGE, 0, 1, 0, sgram_state_pkg::ST_ROW_ACTIVE, 2, 0, 0, 8);
        step(sgram_state_pkg::CMD_NOP, 0, 0, 1, sgram_state_pkg::ST_ROW_ACTIVE, 2, 0, 0, 8);
        flags(6'h00);
        step(sgram_state_pkg::CMD_PRECHARGE, 0, 1, 1, sgram_state_pkg::ST_IDLE, 0, 0, 0, 12);
        repeat (2) @(negedge clk);
        final_report();
    end
endmodule : sgram_power_and_command_state_bench
